// file: sbi_pkg.sv
// How it works
// R01: One flag per direction; the originating side sets it and the receiver may set it again, only the receiver clears it.
// R02: The PC sets the inbound flag with its set-inbound key command.
// R03: The processor clear strobe returns the inbound flag to inactive.
// R04: The processor reassert strobe sets the inbound flag again so no request is lost.
// R05: The inbound flag feeds processor interrupt detect and both status views.
// R06: The processor set strobe raises the outbound flag, both status views and IRQ5.
// R07: The PC clear key command drops the outbound flag and IRQ5.
// R08: The PC may set the outbound flag again with its own key command.
// R09: Key commands are captured into the keys register on the load strobe.
// R10: Internal events are reported through one program level 14 request.
// R11: Cause codes are octal 1 to 7, 10, 11 and 12.
// R12: Power fail is raised by local sense, PC power fail or watchdog expiry.
// R13: A watchdog runs after each outbound interrupt until the PC responds.
// R14: Parity, range, error flag and power fail use cause bits 8, 9, 5, 10.
// R15: A monitor call loads its 8-bit code into the level 14 temporary register.
// R16: The error flag cause is raised while the error flag stays set.
// R17: An I/O error is raised for absent or unauthorised devices or no ident answer.
// R18: Protect, page fault and privileged causes pass only while paging is on.
// R19: Keys bit 0 sets inbound, bit 1 sets outbound, bit 3 clears it, bit 4 enables writes.
// R20: PC status shows inbound in bit 0, outbound in bit 1, stop/clear/power in 5 to 7.
// R21: Reset clears both flags, IRQ5 and the watchdog.
package sbi_pkg;

  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;
  localparam logic [11:0] ADDR_DETECT = 12'h00C;
  localparam logic [11:0] ADDR_ENABLE = 12'h010;
  localparam logic [11:0] ADDR_CAUSE = 12'h014;

  localparam int CMD_CLR_IN = 0;
  localparam int CMD_SET_IN = 1;
  localparam int CMD_SET_OUT = 2;

  localparam int KEY_SET_IN = 0;
  localparam int KEY_SET_OUT = 1;
  localparam int KEY_CLR_OUT = 3;
  localparam int KEY_WR_EN = 4;
  localparam logic [7:0] KEYS_IDLE = 8'hFF;

  localparam int CAUSE_MON = 1;
  localparam int CAUSE_MPV = 2;
  localparam int CAUSE_PF = 3;
  localparam int CAUSE_ILL = 4;
  localparam int CAUSE_ERR = 5;
  localparam int CAUSE_PRIV = 6;
  localparam int CAUSE_IOX = 7;
  localparam int CAUSE_PTY = 8;
  localparam int CAUSE_MOR = 9;
  localparam int CAUSE_POW = 10;
  localparam int NUM_CAUSE = 11;

  localparam int WD_TIMEOUT_US = 1000;
  localparam int CLK_MHZ = 25;
  localparam int WD_CYCLES = WD_TIMEOUT_US * CLK_MHZ;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sbi_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sbi_apb_rsp_t;

endpackage

// file: sbi_signal_box.sv
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
module sbi_signal_box
  import sbi_pkg::*;
#(
  parameter int WD_LIMIT = WD_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Processor register bus
  input wire sbi_apb_req_t apbReq,
  output sbi_apb_rsp_t apbRsp,
  // PC keys port, asynchronous to ref_clk
  input wire logic keysLoadStrobe,
  input wire logic [7:0] pcKeyData,
  input wire logic hostPowerFail,
  input wire logic powerSense,
  // PC side outputs
  output logic [7:0] pcStatus,
  output logic irq5,
  output logic hostMemWriteEnable,
  // Processor interrupt detect
  output logic pcToCpuIrqFlag,
  output logic level14Req,
  // Internal cause events, same clock
  input wire logic monitorCallInstr,
  input wire logic [7:0] monCode,
  input wire logic protectViolation,
  input wire logic pageFault,
  input wire logic illegalInstr,
  input wire logic errorFlag,
  input wire logic privInstr,
  input wire logic ioxNoDevice,
  input wire logic ioxUnauthorised,
  input wire logic identNoAnswer,
  input wire logic dramParityError,
  input wire logic memoryOutOfRange,
  // Processor state shown to the PC
  input wire logic cpuStop,
  input wire logic cpuMasterClear
);

  typedef struct packed {
    logic [1:0] keyStbSync;
    logic keyStbPrev;
    logic [7:0] keyData1;
    logic [7:0] keyData2;
    logic [1:0] hostFailSync;
    logic [1:0] pwrSenseSync;
    logic [7:0] keys;
    logic inFlag;
    logic outFlag;
    logic irq5;
    logic wdRun;
    logic [31:0] wdCount;
    logic pagingOn;
    logic [NUM_CAUSE-1:0] detect;
    logic [NUM_CAUSE-1:0] enable;
    logic [7:0] monTemp;
    logic level14;
    logic [7:0] pcStatus;
    logic memWrEn;
    sbi_apb_rsp_t rsp;
  } sbi_state_t;

  sbi_state_t st;
  sbi_state_t next_st;

  // Highest pending enabled cause; power fail outranks everything
  function automatic logic [3:0] topCause(input logic [NUM_CAUSE-1:0] pend);
    logic [3:0] code;
    code = 4'h0;
    for (int i = 1; i < NUM_CAUSE; i++)
    begin
      if (pend[i])
      begin
        code = 4'(i);
      end
    end
    return code;
  endfunction

  logic keyLoad;
  logic keySetIn;
  logic keySetOut;
  logic keyClrOut;
  logic apbAccess;
  logic apbWrite;
  logic cmdWrite;
  logic cpuClrIn;
  logic cpuSetIn;
  logic cpuSetOut;
  logic wdExpire;
  logic [NUM_CAUSE-1:0] causeSet;
  logic [NUM_CAUSE-1:0] causeClr;
  logic [31:0] rdata;
  logic rdErr;

  always_comb
  begin
    next_st = st;

    // Synchronisers; only stage 1 reads stage 0
    next_st.keyStbSync = {st.keyStbSync[0], keysLoadStrobe};
    next_st.keyData1 = pcKeyData;
    next_st.keyData2 = st.keyData1;
    next_st.keyStbPrev = st.keyStbSync[1];
    next_st.hostFailSync = {st.hostFailSync[0], hostPowerFail};
    next_st.pwrSenseSync = {st.pwrSenseSync[0], powerSense};

    // Key data passes the same two stages as the strobe, so it is settled
    keyLoad = st.keyStbSync[1] & ~st.keyStbPrev;
    if (keyLoad)
    begin
      next_st.keys = st.keyData2; // R09
    end
    // Commands are active low, so the idle value issues none
    // Registered so the pin comes straight from a flip-flop
    next_st.memWrEn = ~next_st.keys[KEY_WR_EN]; // R19
    keySetIn = keyLoad & ~st.keyData2[KEY_SET_IN]; // R19
    keySetOut = keyLoad & ~st.keyData2[KEY_SET_OUT]; // R19
    keyClrOut = keyLoad & ~st.keyData2[KEY_CLR_OUT]; // R19

    // Bus access completes when pready is already high
    apbAccess = apbReq.psel & apbReq.penable & st.rsp.pready;
    apbWrite = apbAccess & apbReq.pwrite;
    cmdWrite = apbWrite & (apbReq.paddr == ADDR_CMD);
    cpuClrIn = cmdWrite & apbReq.pwdata[CMD_CLR_IN];
    cpuSetIn = cmdWrite & apbReq.pwdata[CMD_SET_IN];
    cpuSetOut = cmdWrite & apbReq.pwdata[CMD_SET_OUT];

    // Set wins over clear in every flag
    next_st.inFlag = keySetIn | cpuSetIn | (st.inFlag & ~cpuClrIn); // R01 R02 R03 R04
    next_st.outFlag = cpuSetOut | keySetOut | (st.outFlag & ~keyClrOut); // R01 R06 R07 R08
    next_st.irq5 = next_st.outFlag; // R06 R07

    // Any key load counts as the PC responding
    wdExpire = st.wdRun & (st.wdCount == 32'(WD_LIMIT - 1));
    if (cpuSetOut)
    begin
      next_st.wdRun = 1'b1; // R13
      next_st.wdCount = 32'h0000_0000;
    end
    else if (keyLoad | wdExpire)
    begin
      next_st.wdRun = 1'b0; // R13
      next_st.wdCount = 32'h0000_0000;
    end
    else if (st.wdRun)
    begin
      next_st.wdCount = st.wdCount + 32'h0000_0001;
    end

    causeSet = '0;
    causeSet[CAUSE_MON] = monitorCallInstr; // R11
    causeSet[CAUSE_MPV] = protectViolation & st.pagingOn; // R18
    causeSet[CAUSE_PF] = pageFault & st.pagingOn; // R18
    causeSet[CAUSE_ILL] = illegalInstr;
    causeSet[CAUSE_ERR] = errorFlag; // R14 R16
    causeSet[CAUSE_PRIV] = privInstr & st.pagingOn; // R18
    causeSet[CAUSE_IOX] = ioxNoDevice | ioxUnauthorised | identNoAnswer; // R17
    causeSet[CAUSE_PTY] = dramParityError; // R14
    causeSet[CAUSE_MOR] = memoryOutOfRange; // R14
    causeSet[CAUSE_POW] = st.pwrSenseSync[1] | st.hostFailSync[1] | wdExpire; // R12 R14

    causeClr = '0;
    if (apbWrite & (apbReq.paddr == ADDR_DETECT))
    begin
      causeClr = apbReq.pwdata[NUM_CAUSE-1:0];
    end
    next_st.detect = causeSet | (st.detect & ~causeClr);
    next_st.detect[0] = 1'b0;
    if (monitorCallInstr)
    begin
      next_st.monTemp = monCode; // R15
    end
    next_st.level14 = |(next_st.detect & st.enable); // R10

    next_st.pcStatus = {next_st.detect[CAUSE_POW], cpuMasterClear, cpuStop, 3'b000,
                        next_st.outFlag, next_st.inFlag}; // R05 R06 R20

    if (apbWrite & (apbReq.paddr == ADDR_CTRL))
    begin
      next_st.pagingOn = apbReq.pwdata[0];
    end
    if (apbWrite & (apbReq.paddr == ADDR_ENABLE))
    begin
      next_st.enable = apbReq.pwdata[NUM_CAUSE-1:0];
    end

    rdErr = 1'b0;
    unique case (apbReq.paddr)
      ADDR_CMD: rdata = 32'h0000_0000;
      ADDR_STATUS: rdata = {27'h0, st.level14, ~st.keys[KEY_WR_EN], st.wdRun,
                            st.outFlag, st.inFlag}; // R05 R06
      ADDR_CTRL: rdata = {31'h0, st.pagingOn};
      ADDR_DETECT: rdata = {21'h0, st.detect};
      ADDR_ENABLE: rdata = {21'h0, st.enable};
      ADDR_CAUSE: rdata = {16'h0, st.monTemp, 4'h0,
                           topCause(st.detect & st.enable)}; // R11 R15
      default:
      begin
        rdata = 32'h0000_0000;
        rdErr = 1'b1;
      end
    endcase

    // One wait state: pready rises in the second access cycle
    next_st.rsp.pready = apbReq.psel & apbReq.penable & ~st.rsp.pready;
    next_st.rsp.pslverr = next_st.rsp.pready & rdErr;
    next_st.rsp.prdata = (next_st.rsp.pready & ~apbReq.pwrite) ? rdata : 32'h0000_0000;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0; // R21
      st.keyData1 <= KEYS_IDLE;
      st.keyData2 <= KEYS_IDLE;
      st.keys <= KEYS_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign apbRsp = st.rsp;
  assign pcStatus = st.pcStatus;
  assign irq5 = st.irq5;
  assign hostMemWriteEnable = st.memWrEn;
  assign pcToCpuIrqFlag = st.inFlag;
  assign level14Req = st.level14;

endmodule // sbi_signal_box

// file: sbi_signal_box_chk.sv
`timescale 1ns/1ns
module sbi_signal_box_chk
  import sbi_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Watched ports
  input wire sbi_apb_req_t apbReq,
  input wire sbi_apb_rsp_t apbRsp,
  input wire logic keysLoadStrobe,
  input wire logic [7:0] pcKeyData,
  input wire logic [7:0] pcStatus,
  input wire logic irq5,
  input wire logic pcToCpuIrqFlag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic cmdWr;
  // Command write at the edge that completes it
  assign cmdWr = apbReq.psel & apbReq.penable & apbReq.pwrite & apbRsp.pready
    & (apbReq.paddr == ADDR_CMD);
  property p_om; irq5 == pcStatus[1]; endproperty
  a_om: assert property (p_om) else $error("irq5 and status differ");
  property p_im; pcToCpuIrqFlag == pcStatus[0]; endproperty
  a_im: assert property (p_im) else $error("inbound flag and status differ");
  property p_rs; $fell(sys_rst) |-> !irq5 && !pcToCpuIrqFlag; endproperty
  a_rs: assert property (p_rs) else $error("flag active after reset");
  property p_so; cmdWr && apbReq.pwdata[CMD_SET_OUT] |-> ##[1:2] irq5; endproperty
  a_so: assert property (p_so) else $error("outbound set missed");
  property p_ci;
    cmdWr && apbReq.pwdata[CMD_CLR_IN] && !apbReq.pwdata[CMD_SET_IN] |-> ##[1:2] !pcToCpuIrqFlag;
  endproperty
  a_ci: assert property (p_ci) else $error("inbound clear missed");
  property p_ri; cmdWr && apbReq.pwdata[CMD_SET_IN] |-> ##[1:2] pcToCpuIrqFlag; endproperty
  a_ri: assert property (p_ri) else $error("inbound reassert missed");
  property p_ki;
    $rose(keysLoadStrobe) && !pcKeyData[KEY_SET_IN] |-> ##[2:4] pcToCpuIrqFlag;
  endproperty
  a_ki: assert property (p_ki) else $error("key set inbound missed");
  property p_kc;
    $rose(keysLoadStrobe) && pcKeyData[KEY_SET_OUT] && !pcKeyData[KEY_CLR_OUT] |-> ##[2:4] !irq5;
  endproperty
  a_kc: assert property (p_kc) else $error("key clear outbound missed");
  c_in: cover property ($rose(pcToCpuIrqFlag));
  c_out: cover property ($fell(irq5));
  c_cmd: cover property (cmdWr);
endmodule // sbi_signal_box_chk

// file: sbi_host_model.sv
`timescale 1ns/1ns
module sbi_host_model
  import sbi_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Keys port and power fail toward the device
  output logic keysLoadStrobe,
  output logic [7:0] pcKeyData,
  output logic hostPowerFail
);
  initial
  begin
    keysLoadStrobe = 1'b0;
    pcKeyData = KEYS_IDLE;
    hostPowerFail = 1'b0;
  end
  task automatic load(input logic [7:0] k, input int gap);
    pcKeyData <= k;
    keysLoadStrobe <= 1'b1;
    repeat (3) @(posedge ref_clk);
    keysLoadStrobe <= 1'b0;
    // Released lines must not keep the last value
    pcKeyData <= ~k;
    repeat (gap + 2) @(posedge ref_clk);
  endtask
  // Idle pattern follows each command so no key stays asserted
  task automatic sendKeys(input logic [7:0] k, input int gap);
    load(k, gap);
    load(KEYS_IDLE, gap);
  endtask
  task automatic host_power_fail;
    hostPowerFail <= 1'b1;
    repeat (4) @(posedge ref_clk);
    hostPowerFail <= 1'b0;
  endtask
endmodule // sbi_host_model

// file: sbi_signal_box_tb_top.sv
`timescale 1ns/1ns
module sbi_signal_box_tb_top;
  import sbi_pkg::*;
  localparam int WDL = 20;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  sbi_apb_req_t apbReq = '0;
  sbi_apb_rsp_t apbRsp;
  logic keysLoadStrobe, hostPowerFail, irq5, hostMemWriteEnable, pcToCpuIrqFlag, level14Req, err;
  logic [7:0] pcKeyData, pcStatus;
  logic [7:0] monCode = 8'hA5;
  logic [13:0] ev = '0;
  logic [31:0] q;
  int mismatches = 0;
  int compares = 0;
  int cbit [12] = '{1, 2, 3, 4, 5, 6, 7, 7, 7, 8, 9, 10};

  sbi_signal_box #(.WD_LIMIT(WDL)) dut_u (.*, .monitorCallInstr(ev[0]),
    .protectViolation(ev[1]), .pageFault(ev[2]), .illegalInstr(ev[3]), .errorFlag(ev[4]),
    .privInstr(ev[5]), .ioxNoDevice(ev[6]), .ioxUnauthorised(ev[7]), .identNoAnswer(ev[8]),
    .dramParityError(ev[9]), .memoryOutOfRange(ev[10]), .powerSense(ev[11]),
    .cpuStop(ev[12]), .cpuMasterClear(ev[13]));
  sbi_host_model host_u (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    // Look at pready off the edge; the next rising edge completes the access
    @(negedge ref_clk);
    while (apbRsp.pready !== 1'b1 && n < 40)
    begin
      n++;
      @(negedge ref_clk);
    end
    if (n >= 40)
    begin
      mismatches++;
    end
    q = apbRsp.prdata;
    err = apbRsp.pslverr;
    @(posedge ref_clk);
    apbReq <= '0;
    repeat (2) @(posedge ref_clk);
  endtask
  task pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge ref_clk);
    ev[i] <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
    forever #20 ref_clk = ~ref_clk;
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk(pcStatus, 32'h0);
    apb(1'b1, ADDR_ENABLE, 32'h7FE);
    host_u.sendKeys(8'hFE, 2);
    chk(pcStatus, 32'h1);
    apb(1'b1, ADDR_CMD, 32'h1);
    chk(pcToCpuIrqFlag, 32'h0);
    apb(1'b1, ADDR_CMD, 32'h2);
    chk(pcToCpuIrqFlag, 32'h1);
    apb(1'b1, ADDR_CMD, 32'h5);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q, 32'h6);
    repeat (WDL) @(posedge ref_clk);
    apb(1'b0, ADDR_DETECT, 32'h0);
    chk(q, 32'h400);
    chk(pcStatus, 32'h82);
    apb(1'b1, ADDR_DETECT, 32'h7FE);
    host_u.sendKeys(8'hF7, 6);
    chk(pcStatus, 32'h0);
    host_u.sendKeys(8'hFD, 2);
    chk(irq5, 32'h1);
    host_u.sendKeys(8'hE7, 2);
    host_u.load(8'hEF, 2);
    chk(hostMemWriteEnable, 32'h1);
    host_u.load(KEYS_IDLE, 2);
    chk(hostMemWriteEnable, 32'h0);
    host_u.host_power_fail();
    apb(1'b0, ADDR_DETECT, 32'h0);
    chk(q, 32'h400);
    apb(1'b1, ADDR_DETECT, 32'h7FE);
    $display("flag tests done");
    apb(1'b1, ADDR_CTRL, 32'h1);
    for (int i = 0; i < 12; i++)
    begin
      pulse(i);
      apb(1'b0, ADDR_CAUSE, 32'h0);
      chk(q, {16'h0, monCode, 4'h0, 4'(cbit[i])});
      chk(level14Req, 32'h1);
      apb(1'b0, ADDR_DETECT, 32'h0);
      chk(q, 32'h1 << cbit[i]);
      apb(1'b1, ADDR_DETECT, 32'h7FE);
    end
    apb(1'b1, ADDR_CTRL, 32'h0);
    pulse(2);
    apb(1'b0, ADDR_DETECT, 32'h0);
    chk(q, 32'h0);
    ev[13:12] <= 2'b11;
    apb(1'b0, 12'h018, 32'h0);
    chk(err, 32'h1);
    chk(pcStatus, 32'h60);
    $display("cause tests done");
    complete_run();
  end
endmodule // sbi_signal_box_tb_top

bind sbi_signal_box sbi_signal_box_chk chk_u (.*);
